/* File: rtl/cct_regs.vh */
// How it works
// - Reading counter high byte first latches the low byte for the next low read
// - Latched low byte stays frozen until the low byte is read, despite repeated high reads
// - After a completed sequence a lone low-byte read returns the live low byte
// - Counter wrap from maximum to zero sets the overflow flag in every mode
// - Overflow interrupt asserts only with its enable set and CPU mask clear
// - Overflow flag clears after status read seeing it, then normal low-byte access
// - Shadow counter low-byte accesses never clear the overflow flag
// - Counting continues normally in WAIT mode
// - HALT freezes the counter; reset wake restarts from reset count
// - Clock select both ones selects the external count pin
// - Edge select bit picks rising or falling external clock edges
// - External clock events are synchronised to the CPU clock before counting
// - Internal count rate is CPU clock divided by 2, 4 or 8
// - Active capture edge copies the counter and sets the capture flag
// - One shared capture enable, gated by CPU mask, drives capture interrupts
// - Capture flag clears after status read seeing it, then capture low read
// - Capture high read blocks captures and flag until capture low read
// - In one-pulse or PWM mode only capture channel 2 captures
// - Capture pins always feed the timer, only the selected edge captures
// - Each timer tick both compare values are matched; match sets flag, and interrupt only when enabled
// - On match with output enable the pin takes the programmed level
// - Compare registers are software only and reset to the midpoint
// - Compare output pin latch is low during reset
// - Compare flag clears after status read seeing it, then compare low access
// - Compare high write blocks comparing until compare low write re-enables it
// - Counter resets to FFFC and any counter low write reloads FFFC
// - Shadow counter pair reads the same value as the normal pair
// - Divide by 2 matches on equality, other clocks on compare value plus one
`ifndef CCT_REGS_VH
`define CCT_REGS_VH

// ---------------------------------------------------------------
// Register byte addresses
// ---------------------------------------------------------------
`define CCT_A_CTRL1   8'h00
`define CCT_A_CTRL2   8'h04
`define CCT_A_STATUS  8'h08
`define CCT_A_IC1H    8'h0c
`define CCT_A_IC1L    8'h10
`define CCT_A_OC1H    8'h14
`define CCT_A_OC1L    8'h18
`define CCT_A_CNTH    8'h1c
`define CCT_A_CNTL    8'h20
`define CCT_A_SCNTH   8'h24
`define CCT_A_SCNTL   8'h28
`define CCT_A_IC2H    8'h2c
`define CCT_A_IC2L    8'h30
`define CCT_A_OC2H    8'h34
`define CCT_A_OC2L    8'h38

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define CCT_C1_EDGE1  0
`define CCT_C1_LVL1   1
`define CCT_C1_LVL2   2
`define CCT_C1_OVERFLOW_IRQ_ENABLE   5
`define CCT_C1_COMPARE_IRQ_ENABLE   6
`define CCT_C1_CAPTURE_IRQ_ENABLE   7
`define CCT_C2_EXEDGE 0
`define CCT_C2_CS_LO  1
`define CCT_C2_CS_HI  2
`define CCT_C2_PWM    3
`define CCT_C2_OPM    4
`define CCT_C2_EDGE2  5
`define CCT_C2_OC1E   6
`define CCT_C2_OC2E   7
`define CCT_SR_ICF1   7
`define CCT_SR_OCF1   6
`define CCT_SR_TOF    5
`define CCT_SR_ICF2   4
`define CCT_SR_OCF2   3

// ---------------------------------------------------------------
// Values and encodings
// ---------------------------------------------------------------
`define CCT_CNT_RESET 16'hfffc
`define CCT_CNT_MAX   16'hffff
`define CCT_CMP_RESET 16'h8000
`define CCT_CS_DIV2   2'b00
`define CCT_CS_DIV4   2'b01
`define CCT_CS_DIV8   2'b10
`define CCT_CS_EXT    2'b11
`define CCT_MASK_DIV2 3'h1
`define CCT_MASK_DIV4 3'h3
`define CCT_MASK_DIV8 3'h7
`define CCT_RESP_OKAY 2'b00
`define CCT_RESP_ERR  2'b10

`endif

/* File: rtl/cct_edge_sync.v */
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Two-stage synchroniser with selectable edge pulse
// ---------------------------------------------------------------
module cct_edge_sync (
  input  wire aclk,
  input  wire aresetn,
  input  wire pin,
  input  wire rise_sel,
  output reg  event_q
);
  reg s1_q;
  reg s2_q;
  reg s3_q;

  // First stage feeds only the second one
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1_q    <= 1'b0;
      s2_q    <= 1'b0;
      s3_q    <= 1'b0;
      event_q <= 1'b0;
    end
    else
    begin
      s1_q    <= pin;
      s2_q    <= s1_q;
      s3_q    <= s2_q;
      event_q <= rise_sel ? (s2_q & ~s3_q) : (~s2_q & s3_q);
    end
  end
endmodule // cct_edge_sync

/* File: rtl/cct_prescale.v */
`timescale 1ns/1ps
`include "cct_regs.vh"
// ---------------------------------------------------------------
// Internal count prescaler
// ---------------------------------------------------------------
module cct_prescale (
  input  wire       aclk,
  input  wire       aresetn,
  input  wire       run,
  input  wire [1:0] sel,
  output reg        tick_q
);
  reg  [2:0] div_q;
  reg  [2:0] mask_c;

  always @*
  begin
    case (sel)
      `CCT_CS_DIV2: mask_c = `CCT_MASK_DIV2;
      `CCT_CS_DIV4: mask_c = `CCT_MASK_DIV4;
      default:      mask_c = `CCT_MASK_DIV8;
    endcase
  end

  // Held still while halted so the phase resumes where it stopped
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      div_q  <= 3'h0;
      tick_q <= 1'b0;
    end
    else
    begin
      div_q  <= run ? div_q + 3'h1 : div_q;
      tick_q <= run & ((div_q & mask_c) == mask_c);
    end
  end
endmodule // cct_prescale

/* File: rtl/cct_timer.v */
// The address map and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`include "cct_regs.vh"
module cct_timer (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [31:0] awaddr,
  input  wire [2:0]  awprot,
  input  wire        awvalid,
  output reg         awready,
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wvalid,
  output reg         wready,
  output reg  [1:0]  bresp,
  output reg         bvalid,
  input  wire        bready,
  input  wire [31:0] araddr,
  input  wire [2:0]  arprot,
  input  wire        arvalid,
  output reg         arready,
  output reg  [31:0] rdata,
  output reg  [1:0]  rresp,
  output reg         rvalid,
  input  wire        rready,
  input  wire        cpu_irq_mask,
  input  wire        halt_mode,
  input  wire        ext_count_clock_pin,
  input  wire [1:0]  capture_input_pin,
  output reg  [1:0]  compare_output_pin,
  output reg  [1:0]  compare_output_oe,
  output reg         timer_irq
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function is_at;
    input [31:0] a;
    input [7:0]  off;
    begin
      is_at = (a[31:8] == 24'h0) && (a[7:0] == off);
    end
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  reg  [7:0]  ctrl_one_q;
  reg  [7:0]  ctrl_two_q;
  reg  [15:0] cnt_q;
  reg  [7:0]  low_latch_q;
  reg         low_latched_q;
  reg         overflow_flag_q;
  reg         arm_tof_q;
  reg  [1:0]  capture_flag_q;
  reg  [1:0]  arm_icf_q;
  reg  [1:0]  capture_lock_q;
  reg  [1:0]  compare_flag_q;
  reg  [1:0]  arm_ocf_q;
  reg  [1:0]  compare_hold_q;
  reg  [15:0] capture_value_q [0:1];
  reg  [15:0] compare_value_q [0:1];
  reg         aw_have_q;
  reg  [31:0] awaddr_q;
  reg         w_have_q;
  reg  [7:0]  wbyte_q;
  reg         wlane_q;
  reg  [7:0]  rd_c;
  reg         rok_c;
  reg         wok_c;
  reg  [1:0]  cap_ok_c;
  reg  [1:0]  cmp_hit_c;
  reg  [15:0] target_c;
  integer     i;

  wire        ext_ev;
  wire        pre_tick;
  wire [1:0]  cap_ev;
  wire [1:0]  clk_sel  = {ctrl_two_q[`CCT_C2_CS_HI], ctrl_two_q[`CCT_C2_CS_LO]};
  wire [15:0] cnt_inc  = cnt_q + 16'h0001;
  wire        aw_take  = awvalid & awready;
  wire        w_take   = wvalid & wready;
  wire        ar_take  = arvalid & arready;
  wire        wr_fire  = aw_have_q & w_have_q & ~bvalid;
  wire        wr_en    = wr_fire & wlane_q;
  wire        pulse_md = ctrl_two_q[`CCT_C2_PWM] | ctrl_two_q[`CCT_C2_OPM];
  // Timer clock: external events when both select bits are high
  wire        tick     = ~halt_mode &
                         ((clk_sel == `CCT_CS_EXT) ? ext_ev : pre_tick);
  // No wait input: WAIT leaves the count running untouched

  // Read side effects
  wire rd_sr    = ar_take & is_at(araddr, `CCT_A_STATUS);
  wire rd_cnth  = ar_take & (is_at(araddr, `CCT_A_CNTH) | is_at(araddr, `CCT_A_SCNTH));
  wire rd_cntl  = ar_take & (is_at(araddr, `CCT_A_CNTL) | is_at(araddr, `CCT_A_SCNTL));
  wire rd_ncntl = ar_take & is_at(araddr, `CCT_A_CNTL);
  wire [1:0] rd_ich = {ar_take & is_at(araddr, `CCT_A_IC2H), ar_take & is_at(araddr, `CCT_A_IC1H)};
  wire [1:0] rd_icl = {ar_take & is_at(araddr, `CCT_A_IC2L), ar_take & is_at(araddr, `CCT_A_IC1L)};
  wire [1:0] rd_ocl = {ar_take & is_at(araddr, `CCT_A_OC2L), ar_take & is_at(araddr, `CCT_A_OC1L)};
  // Write side effects
  wire wr_ncntl = wr_en & is_at(awaddr_q, `CCT_A_CNTL);
  wire wr_cntl  = wr_ncntl | (wr_en & is_at(awaddr_q, `CCT_A_SCNTL));
  wire [1:0] wr_och = {wr_en & is_at(awaddr_q, `CCT_A_OC2H), wr_en & is_at(awaddr_q, `CCT_A_OC1H)};
  wire [1:0] wr_ocl = {wr_en & is_at(awaddr_q, `CCT_A_OC2L), wr_en & is_at(awaddr_q, `CCT_A_OC1L)};
  // Flag clears: only the normal low byte touches the overflow flag
  wire       clr_tof = arm_tof_q & (rd_ncntl | wr_ncntl);
  wire [1:0] clr_icf = arm_icf_q & rd_icl;
  wire [1:0] clr_ocf = arm_ocf_q & (rd_ocl | wr_ocl);
  wire [7:0] status  = {capture_flag_q[0], compare_flag_q[0], overflow_flag_q,
                        capture_flag_q[1], compare_flag_q[1], 3'b000};

  // ---------------------------------------------------------------
  // Input synchronisers and prescaler
  // ---------------------------------------------------------------
  // Sampling on the rising edge stands in for the falling-edge resync
  cct_edge_sync u_ext_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .pin      (ext_count_clock_pin),
    .rise_sel (ctrl_two_q[`CCT_C2_EXEDGE]),
    .event_q  (ext_ev)
  );

  cct_edge_sync u_cap1_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .pin      (capture_input_pin[0]),
    .rise_sel (ctrl_one_q[`CCT_C1_EDGE1]),
    .event_q  (cap_ev[0])
  );

  cct_edge_sync u_cap2_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .pin      (capture_input_pin[1]),
    .rise_sel (ctrl_two_q[`CCT_C2_EDGE2]),
    .event_q  (cap_ev[1])
  );

  cct_prescale u_prescale (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (~halt_mode),
    .sel     (clk_sel),
    .tick_q  (pre_tick)
  );

  // ---------------------------------------------------------------
  // Read data decode
  // ---------------------------------------------------------------
  always @*
  begin
    rok_c = 1'b1;
    if (is_at(araddr, `CCT_A_CTRL1))
      rd_c = ctrl_one_q;
    else if (is_at(araddr, `CCT_A_CTRL2))
      rd_c = ctrl_two_q;
    else if (is_at(araddr, `CCT_A_STATUS))
      rd_c = status;
    else if (is_at(araddr, `CCT_A_IC1H))
      rd_c = capture_value_q[0][15:8];
    else if (is_at(araddr, `CCT_A_IC1L))
      rd_c = capture_value_q[0][7:0];
    else if (is_at(araddr, `CCT_A_IC2H))
      rd_c = capture_value_q[1][15:8];
    else if (is_at(araddr, `CCT_A_IC2L))
      rd_c = capture_value_q[1][7:0];
    else if (is_at(araddr, `CCT_A_OC1H))
      rd_c = compare_value_q[0][15:8];
    else if (is_at(araddr, `CCT_A_OC1L))
      rd_c = compare_value_q[0][7:0];
    else if (is_at(araddr, `CCT_A_OC2H))
      rd_c = compare_value_q[1][15:8];
    else if (is_at(araddr, `CCT_A_OC2L))
      rd_c = compare_value_q[1][7:0];
    else if (is_at(araddr, `CCT_A_CNTH) | is_at(araddr, `CCT_A_SCNTH))
      rd_c = cnt_q[15:8];
    else if (is_at(araddr, `CCT_A_CNTL) | is_at(araddr, `CCT_A_SCNTL))
      rd_c = low_latched_q ? low_latch_q : cnt_q[7:0];
    else
    begin
      rd_c  = 8'h00;
      rok_c = 1'b0;
    end
  end

  always @*
  begin
    if (is_at(awaddr_q, `CCT_A_CTRL1) | is_at(awaddr_q, `CCT_A_CTRL2) |
        is_at(awaddr_q, `CCT_A_OC1H) | is_at(awaddr_q, `CCT_A_OC1L) |
        is_at(awaddr_q, `CCT_A_OC2H) | is_at(awaddr_q, `CCT_A_OC2L) |
        is_at(awaddr_q, `CCT_A_CNTL) | is_at(awaddr_q, `CCT_A_SCNTL))
      wok_c = 1'b1;
    else
      wok_c = 1'b0;
  end

  // ---------------------------------------------------------------
  // Compare and capture qualification
  // ---------------------------------------------------------------
  always @*
  begin
    target_c = 16'h0000;
    for (i = 0; i < 2; i = i + 1)
    begin
      // Slower clocks see the match one count later
      target_c     = (clk_sel == `CCT_CS_DIV2) ? compare_value_q[i]
                                                : compare_value_q[i] + 16'h0001;
      cmp_hit_c[i] = tick & ~compare_hold_q[i] & (cnt_inc == target_c);
      cap_ok_c[i]  = cap_ev[i] & ~capture_lock_q[i] & ((i == 1) | ~pulse_md);
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite handshakes
  // ---------------------------------------------------------------
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready   <= 1'b0;
      wready    <= 1'b0;
      arready   <= 1'b0;
      bvalid    <= 1'b0;
      bresp     <= `CCT_RESP_OKAY;
      rvalid    <= 1'b0;
      rresp     <= `CCT_RESP_OKAY;
      rdata     <= 32'h0000_0000;
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= 32'h0000_0000;
      wbyte_q   <= 8'h00;
      wlane_q   <= 1'b0;
    end
    else
    begin
      awready <= ~aw_take & ~(aw_have_q & ~wr_fire);
      wready  <= ~w_take & ~(w_have_q & ~wr_fire);
      arready <= ~ar_take & ~(rvalid & ~rready);
      if (aw_take)
      begin
        aw_have_q <= 1'b1;
        awaddr_q  <= awaddr;
      end
      else if (wr_fire)
        aw_have_q <= 1'b0;
      if (w_take)
      begin
        w_have_q <= 1'b1;
        wbyte_q  <= wdata[7:0];
        wlane_q  <= wstrb[0];
      end
      else if (wr_fire)
        w_have_q <= 1'b0;
      if (wr_fire)
      begin
        bvalid <= 1'b1;
        bresp  <= wok_c ? `CCT_RESP_OKAY : `CCT_RESP_ERR;
      end
      else if (bready)
        bvalid <= 1'b0;
      if (ar_take)
      begin
        rvalid <= 1'b1;
        rdata  <= {24'h000000, rd_c};
        rresp  <= rok_c ? `CCT_RESP_OKAY : `CCT_RESP_ERR;
      end
      else if (rready)
        rvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Counter, flags, capture and compare
  // ---------------------------------------------------------------
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_one_q         <= 8'h00;
      ctrl_two_q         <= 8'h00;
      cnt_q              <= `CCT_CNT_RESET;
      low_latch_q        <= 8'h00;
      low_latched_q      <= 1'b0;
      overflow_flag_q    <= 1'b0;
      arm_tof_q          <= 1'b0;
      capture_flag_q     <= 2'b00;
      arm_icf_q          <= 2'b00;
      capture_lock_q     <= 2'b00;
      compare_flag_q     <= 2'b00;
      arm_ocf_q          <= 2'b00;
      compare_hold_q     <= 2'b00;
      compare_output_pin <= 2'b00;
      compare_output_oe  <= 2'b00;
      timer_irq          <= 1'b0;
      for (i = 0; i < 2; i = i + 1)
      begin
        capture_value_q[i] <= 16'h0000;
        compare_value_q[i] <= `CCT_CMP_RESET;
      end
    end
    else
    begin
      if (wr_en & is_at(awaddr_q, `CCT_A_CTRL1))
        ctrl_one_q <= wbyte_q;
      if (wr_en & is_at(awaddr_q, `CCT_A_CTRL2))
        ctrl_two_q <= wbyte_q;
      // Counter: a low-byte write reloads, otherwise count on tick
      if (wr_cntl)
        cnt_q <= `CCT_CNT_RESET;
      else if (tick)
        cnt_q <= cnt_inc;
      // Two-byte read buffering
      if (rd_cnth & ~low_latched_q)
      begin
        low_latch_q   <= cnt_q[7:0];
        low_latched_q <= 1'b1;
      end
      else if (rd_cntl)
        low_latched_q <= 1'b0;
      // Setting wins over a same-cycle clear
      overflow_flag_q <= (overflow_flag_q & ~clr_tof) |
                         (tick & ~wr_cntl & (cnt_q == `CCT_CNT_MAX));
      if (rd_sr)
        arm_tof_q <= overflow_flag_q;
      else if (rd_ncntl | wr_ncntl)
        arm_tof_q <= 1'b0;
      for (i = 0; i < 2; i = i + 1)
      begin
        // Capture channel
        if (cap_ok_c[i])
          capture_value_q[i] <= cnt_q;
        capture_flag_q[i] <= (capture_flag_q[i] & ~clr_icf[i]) | cap_ok_c[i];
        if (rd_ich[i])
          capture_lock_q[i] <= 1'b1;
        else if (rd_icl[i])
          capture_lock_q[i] <= 1'b0;
        if (rd_sr)
          arm_icf_q[i] <= capture_flag_q[i];
        else if (rd_icl[i])
          arm_icf_q[i] <= 1'b0;
        // Compare channel, value written by software only
        if (wr_och[i])
        begin
          compare_value_q[i][15:8] <= wbyte_q;
          compare_hold_q[i]        <= 1'b1;
        end
        if (wr_ocl[i])
        begin
          compare_value_q[i][7:0] <= wbyte_q;
          compare_hold_q[i]       <= 1'b0;
        end
        compare_flag_q[i] <= (compare_flag_q[i] & ~clr_ocf[i]) | cmp_hit_c[i];
        if (rd_sr)
          arm_ocf_q[i] <= compare_flag_q[i];
        else if (rd_ocl[i] | wr_ocl[i])
          arm_ocf_q[i] <= 1'b0;
      end
      compare_output_oe <= {ctrl_two_q[`CCT_C2_OC2E], ctrl_two_q[`CCT_C2_OC1E]};
      if (cmp_hit_c[0] & ctrl_two_q[`CCT_C2_OC1E])
        compare_output_pin[0] <= ctrl_one_q[`CCT_C1_LVL1];
      if (cmp_hit_c[1] & ctrl_two_q[`CCT_C2_OC2E])
        compare_output_pin[1] <= ctrl_one_q[`CCT_C1_LVL2];
      // Level request; stays pending while masked or disabled
      timer_irq <= ~cpu_irq_mask &
                   ((overflow_flag_q & ctrl_one_q[`CCT_C1_OVERFLOW_IRQ_ENABLE]) |
                    ((|capture_flag_q) & ctrl_one_q[`CCT_C1_CAPTURE_IRQ_ENABLE]) |
                    ((|compare_flag_q) & ctrl_one_q[`CCT_C1_COMPARE_IRQ_ENABLE]));
    end
  end

endmodule // cct_timer

/* File: verif/cct_timer_properties.sv */
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Port checks
// ---------------------------------------------------------------
module cct_timer_properties (
  input wire        aclk,
  input wire        aresetn,
  input wire        awvalid,
  input wire        awready,
  input wire        wvalid,
  input wire        wready,
  input wire        bvalid,
  input wire        bready,
  input wire        arvalid,
  input wire        arready,
  input wire        rvalid,
  input wire        rready,
  input wire        cpu_irq_mask,
  input wire        timer_irq,
  input wire [1:0]  bresp,
  input wire [1:0]  rresp,
  input wire [1:0]  compare_output_pin,
  input wire [31:0] araddr,
  input wire [31:0] rdata
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_ar_take; arvalid && arready; endsequence
  sequence s_wr_take; awvalid && awready && wvalid && wready; endsequence
  // Reset check cannot be switched off by the reset it watches
  property p_pin_rst; disable iff (1'b0) !aresetn |=> compare_output_pin == 2'b00; endproperty
  a_pin_rst: assert property (p_pin_rst) else $error("pin high in reset");
  property p_irq_mask; $past(cpu_irq_mask) |-> !timer_irq; endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq while masked");
  property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("bresp dropped");
  property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("rdata dropped");
  property p_r_lat; s_ar_take |=> rvalid; endproperty
  a_r_lat: assert property (p_r_lat) else $error("read late");
  property p_b_lat; s_wr_take |-> ##[1:3] bvalid; endproperty
  a_b_lat: assert property (p_b_lat) else $error("write late");
  property p_r_zero; rvalid |-> rdata[31:8] == 24'h0; endproperty
  a_r_zero: assert property (p_r_zero) else $error("rdata upper set");
  property p_unmap; s_ar_take ##0 araddr[7:0] > 8'h38 |=> rresp == 2'b10 && rdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read okay");
endmodule // cct_timer_properties

bind cct_timer cct_timer_properties u_props (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
  .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready),
  .cpu_irq_mask(cpu_irq_mask), .timer_irq(timer_irq), .bresp(bresp), .rresp(rresp),
  .compare_output_pin(compare_output_pin), .araddr(araddr), .rdata(rdata)
);

/* File: verif/cct_pins_model.sv */
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Far-side pins: count clock and capture sources
// ---------------------------------------------------------------
module cct_pins_model (
  input  wire       aclk,
  output reg        ext_count_clock_pin = 1'b0,
  output reg  [1:0] capture_input_pin = 2'b00
);
  // Clock idles low between bursts; gap of four or more keeps the edge spacing legal
  task ext_pulses(input int n, input int gap);
    repeat (n)
    begin
      repeat (gap) @(posedge aclk);
      ext_count_clock_pin <= 1'b1;
      repeat (gap) @(posedge aclk);
      ext_count_clock_pin <= 1'b0;
    end
  endtask
  task cap_rise;
    @(posedge aclk);
    capture_input_pin[0] <= 1'b1;
    repeat (6) @(posedge aclk);
    capture_input_pin[0] <= 1'b0;
  endtask
endmodule // cct_pins_model

/* File: verif/test_capture_compare_timer16.sv */
`timescale 1ns/1ps
`include "cct_regs.vh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] %0s exp %h got %h", n, e, g); end end
module test_capture_compare_timer16;
  reg         aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  reg         arvalid = 1'b0, rready = 1'b0, cpu_irq_mask = 1'b1, halt_mode = 1'b0;
  reg  [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
  reg  [7:0]  d;
  reg  [1:0]  rsp;
  int         fails = 0, tests_run = 0;
  wire        awready, wready, bvalid, arready, rvalid, timer_irq, ext_pin;
  wire [1:0]  bresp, rresp, cap_pin, cmp_pin, cmp_oe;
  wire [31:0] rdata;
  cct_timer dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .cpu_irq_mask(cpu_irq_mask), .halt_mode(halt_mode),
    .ext_count_clock_pin(ext_pin), .capture_input_pin(cap_pin), .compare_output_pin(cmp_pin),
    .compare_output_oe(cmp_oe), .timer_irq(timer_irq));
  cct_pins_model pins (.aclk(aclk), .ext_count_clock_pin(ext_pin), .capture_input_pin(cap_pin));
  always #50 aclk = ~aclk;
  // ---------------------------------------------------------------
  // Bus tasks
  // ---------------------------------------------------------------
  task automatic wr(input [7:0] a, v);
    @(posedge aclk);
    awaddr <= {24'h0, a};
    wdata <= {24'h0, v};
    {awvalid, wvalid, bready} <= 3'b111;
    fork
      begin do @(posedge aclk); while (awready !== 1'b1); awvalid <= 1'b0; end
      begin do @(posedge aclk); while (wready !== 1'b1); wvalid <= 1'b0; end
    join
    while (bvalid !== 1'b1) @(posedge aclk);
    bready <= 1'b0;
    rsp = bresp;
  endtask
  task automatic rd(input [7:0] a);
    @(posedge aclk);
    araddr <= {24'h0, a};
    {arvalid, rready} <= 2'b11;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    d = rdata[7:0];
    rsp = rresp;
  endtask
  task automatic rc(input [7:0] a, m, e, input string n);
    rd(a);
    `CHK(n, e, d & m)
  endtask
  task stop_test;
    $display("tests_run %0d fails %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task t_overflow;
    `CHK("pin", 2'b00, cmp_pin)
    rc(`CCT_A_OC1H, 8'hff, 8'h80, "oc1h");
    repeat (10) @(posedge aclk);
    rc(`CCT_A_STATUS, 8'hff, 8'h20, "sr");
    rd(`CCT_A_SCNTL);
    rc(`CCT_A_STATUS, 8'hff, 8'h20, "sr");
    rd(`CCT_A_CNTL);
    rc(`CCT_A_STATUS, 8'hff, 8'h00, "sr");
    wr(`CCT_A_CTRL1, 8'h20);
    wr(`CCT_A_CNTL, 8'h00);
    repeat (20) @(posedge aclk);
    `CHK("irq", 1'b0, timer_irq)
    cpu_irq_mask <= 1'b0;
    repeat (3) @(posedge aclk);
    `CHK("irq", 1'b1, timer_irq)
    cpu_irq_mask <= 1'b1;
    wr(`CCT_A_CTRL1, 8'h00);
  endtask
  // Halt freezes the count, so read values are known exactly
  task t_latch;
    halt_mode <= 1'b1;
    wr(`CCT_A_CNTL, 8'h00);
    rc(`CCT_A_CNTH, 8'hff, 8'hff, "cnth");
    repeat (10) @(posedge aclk);
    rc(`CCT_A_CNTL, 8'hff, 8'hfc, "cntl");
    rd(`CCT_A_CNTH);
    halt_mode <= 1'b0;
    repeat (20) @(posedge aclk);
    halt_mode <= 1'b1;
    rc(`CCT_A_CNTH, 8'hff, 8'h00, "cnth");
    rc(`CCT_A_CNTL, 8'hff, 8'hfc, "cntl");
    rc(`CCT_A_SCNTH, 8'hff, 8'h00, "scnth");
    // Complete the sequence so later low-byte reads are live again
    rd(`CCT_A_SCNTL);
  endtask
  task t_compare;
    wr(`CCT_A_CNTL, 8'h00);
    wr(`CCT_A_OC1H, 8'hff);
    wr(`CCT_A_OC1L, 8'hfe);
    wr(`CCT_A_CTRL1, 8'h02);
    wr(`CCT_A_CTRL2, 8'h40);
    halt_mode <= 1'b0;
    repeat (30) @(posedge aclk);
    `CHK("pin", 2'b01, cmp_pin)
    `CHK("oe", 2'b01, cmp_oe)
    rc(`CCT_A_STATUS, 8'h40, 8'h40, "sr");
    rd(`CCT_A_OC1L);
    rc(`CCT_A_STATUS, 8'h40, 8'h00, "sr");
    halt_mode <= 1'b1;
    wr(`CCT_A_CNTL, 8'h00);
    wr(`CCT_A_OC1H, 8'hff);
    halt_mode <= 1'b0;
    repeat (30) @(posedge aclk);
    rc(`CCT_A_STATUS, 8'h40, 8'h00, "sr");
    wr(`CCT_A_OC1L, 8'hfe);
    wr(`CCT_A_CTRL2, 8'h00);
  endtask
  task t_capture;
    halt_mode <= 1'b1;
    wr(`CCT_A_CNTL, 8'h00);
    wr(`CCT_A_CTRL1, 8'h01);
    pins.cap_rise();
    rc(`CCT_A_STATUS, 8'h80, 8'h80, "sr");
    rc(`CCT_A_IC1H, 8'hff, 8'hff, "ic1h");
    halt_mode <= 1'b0;
    repeat (20) @(posedge aclk);
    halt_mode <= 1'b1;
    pins.cap_rise();
    rc(`CCT_A_IC1L, 8'hff, 8'hfc, "ic1l");
    rc(`CCT_A_STATUS, 8'h80, 8'h00, "sr");
  endtask
  task t_ext;
    halt_mode <= 1'b0;
    wr(`CCT_A_CTRL2, 8'h07);
    wr(`CCT_A_CNTL, 8'h00);
    // Exact external counts pin down the plus-one compare point
    wr(`CCT_A_OC1H, 8'h00);
    rd(`CCT_A_STATUS);
    wr(`CCT_A_OC1L, 8'h02);
    pins.ext_pulses(4, 4);
    repeat (6) @(posedge aclk);
    rc(`CCT_A_CNTH, 8'hff, 8'h00, "cnth");
    rc(`CCT_A_CNTL, 8'hff, 8'h00, "cntl");
    pins.ext_pulses(2, 4);
    repeat (6) @(posedge aclk);
    rc(`CCT_A_CNTL, 8'hff, 8'h02, "cntl");
    rc(`CCT_A_STATUS, 8'h40, 8'h00, "sr");
    pins.ext_pulses(1, 4);
    repeat (6) @(posedge aclk);
    rc(`CCT_A_STATUS, 8'h40, 8'h40, "sr");
  endtask
  task t_bus;
    rd(8'h3c);
    `CHK("rresp", 2'b10, rsp)
    wr(`CCT_A_STATUS, 8'hff);
    `CHK("bresp", 2'b10, rsp)
  endtask
  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_overflow;
    t_latch;
    t_compare;
    t_capture;
    t_ext;
    t_bus;
    stop_test;
  end
  initial
  begin
    repeat (20000) @(posedge aclk);
    fails++;
    stop_test;
  end
endmodule // test_capture_compare_timer16
